// file: common/rcp_pkg.sv
// Shared types and constants for the remote command processing model
`default_nettype none
package rcp_pkg;
    localparam int          IN_DEPTH_DEF   = 16;
    localparam int          OUT_DEPTH_DEF  = 16;
    localparam int          NUM_SETTINGS   = 8;
    localparam logic [7:0]  CH_TERM        = 8'h0a;   // Program message terminator
    localparam logic [7:0]  CH_SEP         = 8'h3b;   // Command separator
    localparam logic [7:0]  CH_QUERY       = 8'h3f;   // Query mark
    localparam logic [7:0]  CH_DIGIT_LO    = 8'h30;
    localparam logic [7:0]  CH_DIGIT_HI    = 8'h39;
    localparam logic [7:0]  CH_KEY_LO      = 8'h41;   // Setting keys 'A'..'H'
    localparam logic [7:0]  VAL_MAX        = 8'hc8;   // Largest legal parameter value
    localparam logic [7:0]  HW_LIMIT       = 8'hf0;   // Sum of settings the hardware takes
    localparam int          SETTLE_TIME_NS = 200;
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // One setting as it is handed to the hardware
    typedef struct packed {
        logic [2:0] key;
        logic [7:0] value;
    } setting_t;

    // Error strobes towards status reporting
    typedef struct packed {
        logic syntax;
        logic range;
        logic exec;
        logic unterminated;
    } err_t;
endpackage
`default_nettype wire

// file: core/char_fifo.sv
// Character buffer with occupancy counter, used for input and output stages
`default_nettype none
module char_fifo
    import rcp_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic         clk,       // System clock
    input  wire logic         rst,       // Synchronous reset, active high
    input  wire logic         clr,       // Empties the buffer
    input  wire logic         wr_en,     // Push a character
    input  wire logic [7:0]   wr_data,   // Character pushed
    input  wire logic         rd_en,     // Pop a character
    output logic      [7:0]   rd_data,   // Oldest character
    output logic              full,      // No room left
    output logic              empty,     // Nothing stored
    output logic      [CW-1:0] count     // Occupancy
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [7:0]    mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic          do_wr, do_rd;

    // Flags come straight from the counter so they never lag a push
    assign full    = (cnt_r == CW'(DEPTH));
    assign empty   = (cnt_r == '0);
    assign count   = cnt_r;
    assign rd_data = mem_r[rp_r];
    assign do_wr   = wr_en && !full;
    assign do_rd   = rd_en && !empty;

    // Pointer and counter next state
    always_comb begin
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (clr) begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end else begin
            if (do_wr) wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            if (do_rd) rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            if (do_wr && !do_rd) cnt_nxt = cnt_r + 1'b1;
            else if (do_rd && !do_wr) cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; contents are only read below the write pointer
    always_ff @(posedge clk) begin
        if (do_wr && !clr) mem_r[wp_r] <= wr_data;
    end

    a_no_overflow: assert property (@(posedge clk) disable iff (rst)
        full |-> ##1 (cnt_r <= CW'(DEPTH))) else $error("buffer count above depth");
endmodule
`default_nettype wire

// file: core/settings_exec.sv
// Execution unit: checks pending settings, drives hardware, tracks settling
`default_nettype none
module settings_exec
    import rcp_pkg::*;
#(
    parameter int NSET = 8
) (
    input  wire logic                  clk,         // System clock
    input  wire logic                  rst,         // Synchronous reset, active high
    input  wire logic                  apply_req,   // End of program message, commit pending
    input  wire logic [NSET-1:0][7:0]  pend_vals,   // Pending settings database
    input  wire logic [NSET-1:0]       pend_dirty,  // Which entries changed
    input  wire logic                  hw_settled,  // Hardware reached new state
    output logic                       busy,        // Commit in progress
    output logic                       exec_err,    // Execution error pulse
    output logic      [NSET-1:0][7:0]  hw_vals,     // Values applied to hardware
    output logic                       hw_load,     // Load pulse to hardware
    output logic                       settling     // Settling flag
);
    typedef enum logic [1:0] {X_IDLE, X_CHECK, X_SETTLE} xst_t;

    xst_t                 st_r, st_nxt;
    logic [NSET-1:0][7:0] hw_r, hw_nxt, merged;
    logic                 set_r, set_nxt, ld_r, ld_nxt, err_r, err_nxt;
    logic [10:0]          sum;      // Eight full bytes need eleven bits, or the check wraps
    logic [7:0]           tmr_r, tmr_nxt;

    // Compatibility check: merged configuration must stay within hardware limit
    always_comb begin
        sum = '0;
        for (int i = 0; i < NSET; i++) begin
            merged[i] = pend_dirty[i] ? pend_vals[i] : hw_r[i];
            sum = sum + 11'(merged[i]);
        end
    end

    always_comb begin
        st_nxt  = st_r;
        hw_nxt  = hw_r;
        set_nxt = set_r;
        ld_nxt  = 1'b0;
        err_nxt = 1'b0;
        tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
        unique case (st_r)
            X_IDLE: if (apply_req) st_nxt = X_CHECK;
            X_CHECK: begin
                if (sum > 11'(HW_LIMIT)) begin
                    err_nxt = 1'b1;
                    st_nxt  = X_IDLE;
                end else begin
                    set_nxt = 1'b1;
                    hw_nxt  = merged;
                    ld_nxt  = 1'b1;
                    tmr_nxt = 8'(SETTLE_CYCLES);
                    st_nxt  = X_SETTLE;
                end
            end
            X_SETTLE: if (hw_settled && tmr_r == '0) begin
                set_nxt = 1'b0;
                st_nxt  = X_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r  <= X_IDLE;
            hw_r  <= '0;
            set_r <= 1'b0;
            ld_r  <= 1'b0;
            err_r <= 1'b0;
            tmr_r <= '0;
        end else begin
            st_r  <= st_nxt;
            hw_r  <= hw_nxt;
            set_r <= set_nxt;
            ld_r  <= ld_nxt;
            err_r <= err_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    assign busy     = (st_r != X_IDLE);
    assign hw_vals  = hw_r;
    assign hw_load  = ld_r;
    assign exec_err = err_r;
    assign settling = set_r;

    a_settle_before_load: assert property (@(posedge clk) disable iff (rst)
        ld_r |-> set_r) else $error("hardware loaded without settling flag");
    a_load_needs_req: assert property (@(posedge clk) disable iff (rst)
        $rose(ld_r) |-> $past(st_r) == X_CHECK && $past(st_r, 2) == X_IDLE)
        else $error("load without commit request");
    a_err_no_load: assert property (@(posedge clk) disable iff (rst)
        err_r |-> !ld_r && $stable(hw_r)) else $error("failed settings applied");
endmodule
`default_nettype wire

// file: core/cmd_processor.sv
// Remote command processor: input buffer, recognizer, database, output buffer
// Behaviour
// - Incoming characters are stored one per cycle in the input buffer.
// - Recognizer is notified on buffer full, terminator or device clear.
// - A full input buffer stalls the host until data is drained.
// - After a terminator, next message characters are taken during execution.
// - Device clear empties the input buffer and resets the recognizer at once.
// - Characters are parsed in arrival order; trigger waits behind earlier commands.
// - Each recognized setting within range goes straight into the pending database.
// - Syntax errors are reported and parsing resumes at the next separator.
// - After syntax passes, the parameter value is range checked.
// - At terminator the commit is handed off and parsing continues.
// - Hardware is updated only on request at end of program message.
// - Incompatible settings raise an execution error and are dropped.
// - Settling flag set in the same cycle as the hardware load, cleared when settled.
// - Queries put the stored value as text into the output buffer.
// - Talk with nothing pending sends nothing and flags unterminated query.
`default_nettype none
module cmd_processor
    import rcp_pkg::*;
#(
    parameter int IN_DEPTH  = IN_DEPTH_DEF,
    parameter int OUT_DEPTH = OUT_DEPTH_DEF
) (
    input  wire logic        SYS_CLK,     // System clock, 25 MHz
    input  wire logic        SYS_RST,     // Synchronous reset, active high
    input  wire logic        RX_VALID,    // Host offers a character
    input  wire logic [7:0]  RX_DATA,     // Command character
    output logic             RX_READY,    // Device accepts characters
    input  wire logic        DEV_CLEAR,   // Device clear interface message
    input  wire logic        TALK_REQ,    // Host addresses device to talk, pulse
    output logic             TX_VALID,    // Response character valid, pulse
    output logic [7:0]       TX_DATA,     // Response character
    input  wire logic        HW_SETTLED,  // Hardware reports settled
    output logic [63:0]      HW_VALUES,   // Applied settings, byte per key
    output logic             HW_LOAD,     // Hardware load pulse
    output logic             SETTLING,    // Operation status settling flag
    output logic             TRIGGER,     // Group execute trigger pulse
    output logic [3:0]       ERR_PULSE    // Syntax, range, execution, unterminated
);
    typedef enum logic [2:0] {P_KEY, P_QMARK, P_VALUE, P_SKIP} pst_t;

    localparam int ICW = $clog2(IN_DEPTH + 1);
    localparam int OCW = $clog2(OUT_DEPTH + 1);

    logic                         in_full, in_empty, in_rd, in_wr;
    logic [7:0]                   in_data;
    logic [ICW-1:0]               in_cnt;
    logic                         out_full, out_empty, out_wr, out_rd;
    logic [7:0]                   out_wdata, out_rdata;
    logic [OCW-1:0]               out_cnt;
    pst_t                         ps_r, ps_nxt;
    logic [2:0]                   key_r, key_nxt;
    logic [8:0]                   val_r, val_nxt;
    logic                         digit_r, digit_nxt;
    logic [NUM_SETTINGS-1:0][7:0] db_r, db_nxt;
    logic [NUM_SETTINGS-1:0]      dirty_r, dirty_nxt;
    logic                         apply_nxt, apply_r, take_nxt, take_r;
    logic                         trig_nxt, trig_r, stall_r, stall_nxt;
    logic [3:0]                   err_nxt, err_r;
    logic                         tx_v_r, tx_v_nxt;
    logic [7:0]                   tx_d_r, tx_d_nxt;
    logic [1:0]                   qph_r, qph_nxt;
    logic [7:0]                   qval_r, qval_nxt;
    logic                         xbusy, xerr, xload, xsettle;
    logic [NUM_SETTINGS-1:0][7:0] xvals;
    logic                         is_digit, is_key, ch_term, ch_sep;

    // Host is held off while the buffer is full or the recognizer drains it
    assign in_wr = RX_VALID && RX_READY && !DEV_CLEAR;

    char_fifo #(.DEPTH(IN_DEPTH)) u_in (
        .clk     (SYS_CLK),
        .rst     (SYS_RST),
        .clr     (DEV_CLEAR),
        .wr_en   (in_wr),
        .wr_data (RX_DATA),
        .rd_en   (in_rd),
        .rd_data (in_data),
        .full    (in_full),
        .empty   (in_empty),
        .count   (in_cnt)
    );

    char_fifo #(.DEPTH(OUT_DEPTH)) u_out (
        .clk     (SYS_CLK),
        .rst     (SYS_RST),
        .clr     (DEV_CLEAR),
        .wr_en   (out_wr),
        .wr_data (out_wdata),
        .rd_en   (out_rd),
        .rd_data (out_rdata),
        .full    (out_full),
        .empty   (out_empty),
        .count   (out_cnt)
    );

    settings_exec #(.NSET(NUM_SETTINGS)) u_exec (
        .clk        (SYS_CLK),
        .rst        (SYS_RST),
        .apply_req  (apply_r),
        .pend_vals  (db_r),
        .pend_dirty (dirty_r),
        .hw_settled (HW_SETTLED),
        .busy       (xbusy),
        .exec_err   (xerr),
        .hw_vals    (xvals),
        .hw_load    (xload),
        .settling   (xsettle)
    );

    assign is_digit = (in_data >= CH_DIGIT_LO) && (in_data <= CH_DIGIT_HI);
    assign is_key   = (in_data >= CH_KEY_LO) && (in_data < CH_KEY_LO + 8'(NUM_SETTINGS));
    assign ch_term  = (in_data == CH_TERM);
    assign ch_sep   = (in_data == CH_SEP);

    // Recognizer consumes one character per cycle in arrival order; a pending
    // query response holds it, and an unfinished commit holds it at a terminator, so results stay ordered
    always_comb begin
        ps_nxt    = ps_r;
        key_nxt   = key_r;
        val_nxt   = val_r;
        digit_nxt = digit_r;
        db_nxt    = db_r;
        dirty_nxt = dirty_r;
        apply_nxt = 1'b0;
        take_nxt  = apply_r;
        trig_nxt  = 1'b0;
        err_nxt   = 4'h0;
        qph_nxt   = qph_r;
        qval_nxt  = qval_r;
        in_rd     = 1'b0;
        out_wr    = 1'b0;
        out_wdata = 8'h00;
        stall_nxt = stall_r;
        // Full buffer latches the stall until the buffer is fully drained
        if (in_full) stall_nxt = 1'b1;
        else if (in_empty) stall_nxt = 1'b0;
        // Exec reads the dirty mask in its check state, one cycle after the request
        if (take_r) dirty_nxt = '0;
        if (qph_r != 2'd0) begin
            // Query response: three digits, no terminator
            if (!out_full) begin
                out_wr    = 1'b1;
                unique case (qph_r)
                    2'd3: out_wdata = CH_DIGIT_LO + 8'(qval_r / 8'd100);
                    2'd2: out_wdata = CH_DIGIT_LO + 8'((qval_r / 8'd10) % 8'd10);
                    2'd1: out_wdata = CH_DIGIT_LO + 8'(qval_r % 8'd10);
                    default: out_wdata = CH_TERM;
                endcase
                qph_nxt = (qph_r == 2'd1) ? 2'd0 : qph_r - 2'd1;
                if (qph_r == 2'd1) begin
                    out_wdata = CH_DIGIT_LO + 8'(qval_r % 8'd10);
                end
            end
        end else if (!in_empty && !(xbusy && ch_term) && !apply_r) begin
            in_rd = 1'b1;
            unique case (ps_r)
                P_KEY: begin
                    if (ch_term) begin
                        apply_nxt = |dirty_r;
                    end else if (in_data == 8'h2a) begin
                        trig_nxt = 1'b1;
                    end else if (is_key) begin
                        key_nxt   = 3'(in_data - CH_KEY_LO);
                        val_nxt   = '0;
                        digit_nxt = 1'b0;
                        ps_nxt    = P_QMARK;
                    end else if (!ch_sep) begin
                        err_nxt[3] = 1'b1;
                        ps_nxt     = P_SKIP;
                    end
                end
                P_QMARK: begin
                    if (in_data == CH_QUERY) begin
                        qval_nxt = db_r[key_r];
                        qph_nxt  = 2'd3;
                        ps_nxt   = P_KEY;
                    end else if (is_digit) begin
                        val_nxt   = 9'(in_data - CH_DIGIT_LO);
                        digit_nxt = 1'b1;
                        ps_nxt    = P_VALUE;
                    end else begin
                        err_nxt[3] = 1'b1;
                        ps_nxt     = (ch_term || ch_sep) ? P_KEY : P_SKIP;
                        apply_nxt  = ch_term && |dirty_r;
                    end
                end
                P_VALUE: begin
                    if (is_digit) begin
                        // Saturate early so the 9-bit product cannot wrap back into range
                        val_nxt = (val_r > 9'd25) ? 9'd256
                                : 9'(val_r * 9'd10 + 9'(in_data - CH_DIGIT_LO));
                    end else if (ch_sep || ch_term) begin
                        if (val_r > 9'(VAL_MAX)) begin
                            err_nxt[2] = 1'b1;
                        end else begin
                            db_nxt[key_r]    = 8'(val_r);
                            dirty_nxt[key_r] = 1'b1;
                        end
                        ps_nxt    = P_KEY;
                        apply_nxt = ch_term && (|dirty_r || val_r <= 9'(VAL_MAX));
                    end else begin
                        err_nxt[3] = 1'b1;
                        ps_nxt     = P_SKIP;
                    end
                end
                P_SKIP: begin
                    // Resume at the next separator so the rest is still serviced
                    if (ch_sep) ps_nxt = P_KEY;
                    else if (ch_term) begin
                        ps_nxt    = P_KEY;
                        apply_nxt = |dirty_r;
                    end
                end
                default: ps_nxt = P_KEY;
            endcase
        end
        if (DEV_CLEAR) begin
            ps_nxt    = P_KEY;
            qph_nxt   = 2'd0;
            apply_nxt = 1'b0;
            trig_nxt  = 1'b0;
            stall_nxt = 1'b0;
            dirty_nxt = '0;
        end
        err_nxt[1] = xerr;
        // Talk with nothing stored or being formatted sends nothing
        err_nxt[0] = TALK_REQ && out_empty && qph_r == 2'd0;
    end

    // Talk request drains one response character; empty buffer sends nothing
    always_comb begin
        out_rd   = TALK_REQ && !out_empty;
        tx_v_nxt = out_rd;
        tx_d_nxt = out_rd ? out_rdata : 8'h00;
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ps_r    <= P_KEY;
            key_r   <= '0;
            val_r   <= '0;
            digit_r <= 1'b0;
            db_r    <= '0;
            dirty_r <= '0;
            apply_r <= 1'b0;
            take_r  <= 1'b0;
            trig_r  <= 1'b0;
            err_r   <= 4'h0;
            qph_r   <= 2'd0;
            qval_r  <= '0;
            stall_r <= 1'b0;
            tx_v_r  <= 1'b0;
            tx_d_r  <= 8'h00;
        end else begin
            ps_r    <= ps_nxt;
            key_r   <= key_nxt;
            val_r   <= val_nxt;
            digit_r <= digit_nxt;
            db_r    <= db_nxt;
            dirty_r <= dirty_nxt;
            apply_r <= apply_nxt;
            take_r  <= take_nxt;
            trig_r  <= trig_nxt;
            err_r   <= err_nxt;
            qph_r   <= qph_nxt;
            qval_r  <= qval_nxt;
            stall_r <= stall_nxt;
            tx_v_r  <= tx_v_nxt;
            tx_d_r  <= tx_d_nxt;
        end
    end

    // Ready registered so it comes straight from a flip-flop
    logic rdy_r;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) rdy_r <= 1'b0;
        else rdy_r <= !stall_nxt && (in_cnt + ICW'(in_wr) < ICW'(IN_DEPTH));
    end

    assign RX_READY  = rdy_r;
    assign TX_VALID  = tx_v_r;
    assign TX_DATA   = tx_d_r;
    assign HW_VALUES = xvals;
    assign HW_LOAD   = xload;
    assign SETTLING  = xsettle;
    assign TRIGGER   = trig_r;
    assign ERR_PULSE = err_r;

    sequence s_clear;
        DEV_CLEAR;
    endsequence
    sequence s_idle_after;
        ps_r == P_KEY && qph_r == 2'd0;
    endsequence

    a_clear_resets: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        s_clear |=> s_idle_after) else $error("clear did not reset recognizer");
    a_clear_empties: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        DEV_CLEAR |=> in_cnt == '0) else $error("clear left input data");
    a_no_take_full: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        in_full |=> !RX_READY) else $error("ready while buffer full");
    a_silent_talk: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        TALK_REQ && out_empty && qph_r == 2'd0 |=> !TX_VALID && ERR_PULSE[0])
        else $error("empty talk not flagged");
    a_apply_at_term: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        $rose(apply_r) |-> $past(in_rd && ch_term)) else $error("commit not at terminator");
    a_range_drop: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        ERR_PULSE[2] |-> $stable(db_r)) else $error("out of range stored");
endmodule
`default_nettype wire

// file: bench/host_model.sv
// Remote host model: offers characters and talk requests
`default_nettype none
module host_model
    import rcp_pkg::*;
(
    input  wire logic       clk,    // System clock
    input  wire logic       ready,  // Device takes characters
    output logic            valid,  // Character offered
    output logic      [7:0] data,   // Character
    output logic            talk    // Talk request pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    initial valid = 1'b0;
    initial data = 8'h00;
    initial talk = 1'b0;
    // Hold until ready is seen; a released line shows the inverse, never the stale char
    task automatic send_char(input logic [7:0] c);
        int n;
        n = 0;
        @(negedge clk);
        valid = 1'b1;
        data = c;
        while (!ready && n < 2000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        valid = 1'b0;
        data = ~c;
    endtask
    task automatic send_str(input string s);
        foreach (s[i]) send_char(s[i]);
    endtask
    // Talk request pulse of one cycle; the host does not wait for a response
    task automatic talk_once();
        @(negedge clk);
        talk = 1'b1;
        @(negedge clk);
        talk = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: bench/remote_command_processing_model_test.sv
// Self-checking bench for the remote command processor
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
module remote_command_processing_model_test
    import rcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hw_settled = 1'b1;
    logic        rx_valid, rx_ready, dev_clear, talk, tx_valid, hw_load, settling, trigger;
    logic [7:0]  rx_data, tx_data;
    logic [63:0] hw_values;
    logic [3:0]  err_pulse, err_seen;
    logic        trig_seen, bad_load, full_seen;
    int          num_errors = 0, checks_done = 0, cycles = 0, loads = 0, scnt = 0, v;
    int          sv[8] = '{default: 0};
    logic [7:0]  txq[$];
    always #20 clk = ~clk;
    // Small depths so that long messages stall the host
    cmd_processor #(.IN_DEPTH(4), .OUT_DEPTH(4)) u_cmd_processor (
        .SYS_CLK(clk), .SYS_RST(rst), .RX_VALID(rx_valid), .RX_DATA(rx_data),
        .RX_READY(rx_ready), .DEV_CLEAR(dev_clear), .TALK_REQ(talk), .TX_VALID(tx_valid),
        .TX_DATA(tx_data), .HW_SETTLED(hw_settled), .HW_VALUES(hw_values),
        .HW_LOAD(hw_load), .SETTLING(settling), .TRIGGER(trigger), .ERR_PULSE(err_pulse));
    host_model u_host_model (.clk(clk), .ready(rx_ready), .valid(rx_valid),
        .data(rx_data), .talk(talk));
    // Sticky capture of pulses, responses and loads
    always @(posedge clk) begin
        err_seen <= err_seen | err_pulse;
        trig_seen <= trig_seen | trigger;
        full_seen <= full_seen | u_cmd_processor.in_full;
        if (hw_load) loads <= loads + 1;
        if (hw_load && !settling) bad_load <= 1'b1;
        if (tx_valid) txq.push_back(tx_data);
    end
    // Hardware settles eight cycles after a load, past the design's own minimum
    // settle count, so the settled input decides; cycle ceiling cuts a hang
    always @(negedge clk) begin
        if (hw_load) scnt = 8;
        else if (scnt > 0) scnt--;
        hw_settled = (scnt == 0);
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            end_sim();
        end
    end
    // One message, then events and applied values against the model
    task automatic run(string name, string m, logic [3:0] e_err, int e_loads);
        int n;
        n = 0;
        err_seen = 4'h0;
        trig_seen = 1'b0;
        loads = 0;
        bad_load = 1'b0;
        full_seen = 1'b0;
        u_host_model.send_str(m);
        repeat (30) @(negedge clk);
        while (settling && n < 500) begin
            @(negedge clk);
            n++;
        end
        `CHK({name, " busy"}, 1'b0, settling)
        `CHK({name, " err"}, e_err, err_seen)
        if (e_loads >= 0) `CHK({name, " loads"}, e_loads, loads)
        `CHK({name, " settle"}, 1'b0, bad_load)
        for (n = 0; n < 8; n++) `CHK({name, " hw"}, 8'(sv[n]), hw_values[n*8 +: 8])
        $display("test %s done", name);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        string q;
        int    k;
        dev_clear = 1'b0;
        void'($urandom(32'h87e2dd3c));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        sv[0] = 5;
        run("write", "A5\n", 4'h0, 1);
        v = $urandom % 201;
        sv[2] = v;
        run("random", $sformatf("C%0d\n", v), 4'h0, 1);
        run("range", "B201;B600\n", 4'b0100, 0);
        sv[3] = 9;
        run("syntax", "Z;H;D9\n", 4'b1000, 1);
        run("exec", "E200;F100\n", 4'b0010, 0);
        run("trigger", "*\n", 4'h0, 0);
        `CHK("trigger", 1'b1, trig_seen)
        sv[6] = 5;
        // Second terminator waits behind the first commit, so later chars fill the buffer
        run("full", "G1\n\nG2;G3;G4;G5\n", 4'h0, 2);
        `CHK("full", 1'b1, full_seen)
        u_host_model.send_str("A7");
        @(negedge clk);
        dev_clear = 1'b1;
        @(negedge clk);
        dev_clear = 1'b0;
        run("clear", "\n", 4'h0, 0);
        txq.delete();
        run("query", "A?\n", 4'h0, 0);
        repeat (3) u_host_model.talk_once();
        repeat (3) @(negedge clk);
        q = $sformatf("%03d", sv[0]);
        `CHK("tx count", 3, txq.size())
        for (k = 0; k < 3; k++) `CHK("tx char", q[k], txq[k])
        err_seen = 4'h0;
        u_host_model.talk_once();
        repeat (4) @(negedge clk);
        `CHK("unterminated", 4'b0001, err_seen)
        `CHK("silent talk", 3, txq.size())
        $display("test talk done");
        end_sim();
    end
endmodule
`default_nettype wire
